// File: design/cas_alarm_if.sv
// carries raw alarm levels into the synchroniser and the clean copy back
interface cas_alarm_if #(
  parameter int W = 10
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : cas_alarm_if

// File: design/cas_pkg.sv
// Functional notes
// - alternate input predivider low byte is read/write; ratio is value plus one
// - range selects: input B in bits 5:3, input A in 2:0, 7:6 reserved
// - input B active bit reads 1 only when selected and no signal loss
// - input A active bit reads 1 only when selected and no signal loss
// - bit 2 shows live signal loss of clock input B
// - bit 1 shows live signal loss of clock input A
// - bit 0 shows live signal loss of the crystal or external reference
// - bit 7 reads 1 while a coarse skew change is still applied
// - bit 6 reads 1 once holdover history holds enough valid samples
// - bit 2 shows live frequency offset alarm of clock input B
// - bit 1 shows live frequency offset alarm of clock input A
// - bit 0 reads 1 while the PLL is unlocked, 0 when locked
// - each loss, unlock and offset alarm has a sticky copy, cleared by writing 0, raising interrupt
package cas_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INT_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_PREDIV_LO = 8'h30;
  localparam logic [7:0] ADDR_RANGE     = 8'h37;
  localparam logic [7:0] ADDR_ACTIVE    = 8'h80;
  localparam logic [7:0] ADDR_LOS       = 8'h81;
  localparam logic [7:0] ADDR_STAT      = 8'h82;
  localparam logic [7:0] ADDR_LOS_FLAG  = 8'h83;
  localparam logic [7:0] ADDR_STAT_FLAG = 8'h84;
  localparam logic [7:0] ADDR_LOS_MASK  = 8'h8b;
  localparam logic [7:0] ADDR_STAT_MASK = 8'h8c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RANGE_W      = 3;
  localparam int RANGE_A_LSB  = 0;
  localparam int RANGE_B_LSB  = 3;
  localparam int STAT_FLD_LSB = 1;
  localparam int LOS_GROUP_N  = 3;

  // bit order of the synchronised alarm vector
  localparam int AL_REF_LOS   = 0;
  localparam int AL_A_LOS     = 1;
  localparam int AL_B_LOS     = 2;
  localparam int AL_UNLOCK    = 3;
  localparam int AL_A_OFFSET  = 4;
  localparam int AL_B_OFFSET  = 5;
  localparam int AL_SKEW_BUSY = 6;
  localparam int AL_HOLD_RDY  = 7;
  localparam int AL_A_SEL     = 8;
  localparam int AL_B_SEL     = 9;
  localparam int ALARM_W      = 10;
  localparam int STICKY_N     = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]          PREDIV_LO_RST = 8'h00;
  localparam logic [RANGE_W-1:0]  RANGE_RST     = 3'h0;
  localparam logic [STICKY_N-1:0] MASK_RST      = 6'h3f;
  localparam logic                INT_EN_RST    = 1'b0;

endpackage : cas_pkg

// File: design/cas_regs.sv
// alarm status and input monitoring register bank
module cas_regs (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  // register access port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  // live alarms from the monitors
  input  wire logic       i_reference_signal_loss,
  input  wire logic       i_input_a_signal_loss,
  input  wire logic       i_input_b_signal_loss,
  input  wire logic       i_pll_unlock,
  input  wire logic       i_input_a_offset,
  input  wire logic       i_input_b_offset,
  input  wire logic       i_coarse_skew_busy,
  input  wire logic       i_holdover_ready,
  // reference selection from the input switch
  input  wire logic       i_input_a_selected,
  input  wire logic       i_input_b_selected,
  // programmed settings
  output logic      [7:0] o_alt_input_predivider_low,
  output logic      [2:0] o_input_a_range_select,
  output logic      [2:0] o_input_b_range_select,
  // interrupt
  output logic            o_irq
);

  localparam int AW = cas_pkg::ALARM_W;
  localparam int SN = cas_pkg::STICKY_N;
  localparam int RW = cas_pkg::RANGE_W;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  wire logic wr_int_ctrl  = i_reg_wr & hit(i_reg_addr, cas_pkg::ADDR_INT_CTRL);
  wire logic wr_prediv    = i_reg_wr &
                            hit(i_reg_addr, cas_pkg::ADDR_PREDIV_LO);
  wire logic wr_range     = i_reg_wr & hit(i_reg_addr, cas_pkg::ADDR_RANGE);
  wire logic wr_los_flag  = i_reg_wr &
                            hit(i_reg_addr, cas_pkg::ADDR_LOS_FLAG);
  wire logic wr_stat_flag = i_reg_wr &
                            hit(i_reg_addr, cas_pkg::ADDR_STAT_FLAG);
  wire logic wr_los_mask  = i_reg_wr &
                            hit(i_reg_addr, cas_pkg::ADDR_LOS_MASK);
  wire logic wr_stat_mask = i_reg_wr &
                            hit(i_reg_addr, cas_pkg::ADDR_STAT_MASK);

  // ---------------------------------------------------------------
  // live alarm synchronisation
  // ---------------------------------------------------------------
  cas_alarm_if #(.W(AW)) alarm_bus ();

  // monitors run off the input clocks, so every level is retimed first
  assign alarm_bus.raw = {i_input_b_selected,
                          i_input_a_selected,
                          i_holdover_ready,
                          i_coarse_skew_busy,
                          i_input_b_offset,
                          i_input_a_offset,
                          i_pll_unlock,
                          i_input_b_signal_loss,
                          i_input_a_signal_loss,
                          i_reference_signal_loss};

  cas_sync #(.W(AW)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .bus       (alarm_bus.sync)
  );

  wire logic [AW-1:0] live = alarm_bus.synced;

  // a lost input can never count as the active reference
  wire logic act_a = live[cas_pkg::AL_A_SEL] &
                     ~live[cas_pkg::AL_A_LOS];
  wire logic act_b = live[cas_pkg::AL_B_SEL] &
                     ~live[cas_pkg::AL_B_LOS];

  // ---------------------------------------------------------------
  // writable settings
  // ---------------------------------------------------------------
  logic [7:0]    prediv_lo;
  logic [RW-1:0] range_a;
  logic [RW-1:0] range_b;
  logic [SN-1:0] mask;
  logic          int_en;
  logic [SN-1:0] flag;

  wire logic [7:0] next_prediv_lo = wr_prediv ? i_reg_wdata : prediv_lo;
  // bits 7:6 of the range word are dropped
  wire logic [RW-1:0] next_range_a =
    wr_range ? i_reg_wdata[cas_pkg::RANGE_A_LSB +: RW] : range_a;
  wire logic [RW-1:0] next_range_b =
    wr_range ? i_reg_wdata[cas_pkg::RANGE_B_LSB +: RW] : range_b;
  wire logic next_int_en = wr_int_ctrl ? i_reg_wdata[0] : int_en;
  wire logic [SN-1:0] next_mask =
    wr_los_mask  ? {mask[5:3], i_reg_wdata[2:0]} :
    wr_stat_mask ? {i_reg_wdata[3:1], mask[2:0]} : mask;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      prediv_lo <= cas_pkg::PREDIV_LO_RST;
      range_a   <= cas_pkg::RANGE_RST;
      range_b   <= cas_pkg::RANGE_RST;
      mask      <= cas_pkg::MASK_RST;
      int_en    <= cas_pkg::INT_EN_RST;
    end else begin
      prediv_lo <= next_prediv_lo;
      range_a   <= next_range_a;
      range_b   <= next_range_b;
      mask      <= next_mask;
      int_en    <= next_int_en;
    end
  end

  // ---------------------------------------------------------------
  // sticky alarm copies
  // ---------------------------------------------------------------
  logic [SN-1:0] next_flag;

  genvar gi;
  generate
    for (gi = 0; gi < SN; gi++) begin : g_flag
      localparam int WB = (gi < cas_pkg::LOS_GROUP_N) ? gi :
                          gi - cas_pkg::LOS_GROUP_N + cas_pkg::STAT_FLD_LSB;
      wire logic grp_wr = (gi < cas_pkg::LOS_GROUP_N) ? wr_los_flag :
                                                        wr_stat_flag;
      wire logic clr = grp_wr & ~i_reg_wdata[WB];
      // a live alarm in the clearing cycle keeps the flag set
      assign next_flag[gi] = live[gi] | (flag[gi] & ~clr);
    end
  endgenerate

  wire logic next_irq = int_en & (|(flag & ~mask));

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      flag  <= '0;
      o_irq <= 1'b0;
    end else begin
      flag  <= next_flag;
      o_irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire logic [7:0] rd_range  = {2'h0, range_b, range_a};
  wire logic [7:0] rd_active = {6'h0, act_b, act_a};
  wire logic [7:0] rd_los    = {5'h0,
                                live[cas_pkg::AL_B_LOS],
                                live[cas_pkg::AL_A_LOS],
                                live[cas_pkg::AL_REF_LOS]};
  wire logic [7:0] rd_stat   = {live[cas_pkg::AL_SKEW_BUSY],
                                live[cas_pkg::AL_HOLD_RDY],
                                3'h0,
                                live[cas_pkg::AL_B_OFFSET],
                                live[cas_pkg::AL_A_OFFSET],
                                live[cas_pkg::AL_UNLOCK]};
  wire logic [7:0] rd_lflag  = {5'h0, flag[2:0]};
  wire logic [7:0] rd_sflag  = {4'h0, flag[5:3], 1'b0};
  wire logic [7:0] rd_lmask  = {5'h0, mask[2:0]};
  wire logic [7:0] rd_smask  = {4'h0, mask[5:3], 1'b0};
  wire logic [7:0] rd_intc   = {7'h0, int_en};

  // unmapped offsets read as zero
  wire logic [7:0] rd_mux =
    hit(i_reg_addr, cas_pkg::ADDR_INT_CTRL)  ? rd_intc   :
    hit(i_reg_addr, cas_pkg::ADDR_PREDIV_LO) ? prediv_lo :
    hit(i_reg_addr, cas_pkg::ADDR_RANGE)     ? rd_range  :
    hit(i_reg_addr, cas_pkg::ADDR_ACTIVE)    ? rd_active :
    hit(i_reg_addr, cas_pkg::ADDR_LOS)       ? rd_los    :
    hit(i_reg_addr, cas_pkg::ADDR_STAT)      ? rd_stat   :
    hit(i_reg_addr, cas_pkg::ADDR_LOS_FLAG)  ? rd_lflag  :
    hit(i_reg_addr, cas_pkg::ADDR_STAT_FLAG) ? rd_sflag  :
    hit(i_reg_addr, cas_pkg::ADDR_LOS_MASK)  ? rd_lmask  :
    hit(i_reg_addr, cas_pkg::ADDR_STAT_MASK) ? rd_smask  : 8'h00;

  // data is held until the next read so software may sample it late
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // settings outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_alt_input_predivider_low <= cas_pkg::PREDIV_LO_RST;
      o_input_a_range_select     <= cas_pkg::RANGE_RST;
      o_input_b_range_select     <= cas_pkg::RANGE_RST;
    end else begin
      o_alt_input_predivider_low <= next_prediv_lo;
      o_input_a_range_select     <= next_range_a;
      o_input_b_range_select     <= next_range_b;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_prediv_wr;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    wr_prediv |=> o_alt_input_predivider_low == $past(i_reg_wdata);
  endproperty
  a_prediv_wr: assert property (p_prediv_wr)
    else $error("predivider low byte not written");

  property p_range_wr;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    wr_range |=> o_input_b_range_select == $past(i_reg_wdata[5:3]) &&
                 o_input_a_range_select == $past(i_reg_wdata[2:0]);
  endproperty
  a_range_wr: assert property (p_range_wr)
    else $error("range select fields misplaced");

  property p_act_b;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && hit(i_reg_addr, cas_pkg::ADDR_ACTIVE) &&
     live[cas_pkg::AL_B_LOS]) |=> !o_reg_rdata[1];
  endproperty
  a_act_b: assert property (p_act_b)
    else $error("lost input b shown active");

  property p_act_a;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && hit(i_reg_addr, cas_pkg::ADDR_ACTIVE) &&
     live[cas_pkg::AL_A_SEL] && !live[cas_pkg::AL_A_LOS]) |=> o_reg_rdata[0];
  endproperty
  a_act_a: assert property (p_act_a)
    else $error("selected input a not shown active");

  property p_los_read;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && hit(i_reg_addr, cas_pkg::ADDR_LOS)) |=>
      o_reg_rvalid && o_reg_rdata == {5'h0, $past(live[2:0])};
  endproperty
  a_los_read: assert property (p_los_read)
    else $error("signal loss status read wrong");

  property p_stat_read;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && hit(i_reg_addr, cas_pkg::ADDR_STAT)) |=>
      o_reg_rdata[7] == $past(live[cas_pkg::AL_SKEW_BUSY]) &&
      o_reg_rdata[6] == $past(live[cas_pkg::AL_HOLD_RDY]) &&
      o_reg_rdata[5:3] == 3'h0 &&
      o_reg_rdata[2:0] == $past(live[5:3]);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("pll and offset status read wrong");

  property p_sticky_set;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    live[cas_pkg::AL_UNLOCK] [*2] |-> ##1 flag[cas_pkg::AL_UNLOCK] [*2];
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("unlock flag not held");

  property p_irq;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (int_en && |(flag & ~mask)) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised for unmasked flag");

  property p_ro_write;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_wr && (hit(i_reg_addr, cas_pkg::ADDR_ACTIVE) ||
                  hit(i_reg_addr, cas_pkg::ADDR_STAT))) |=>
      $stable(o_alt_input_predivider_low) &&
      $stable(o_input_a_range_select) && $stable(o_input_b_range_select);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to read-only register changed a setting");

endmodule // cas_regs

// File: design/cas_sync.sv
// two-flop synchroniser for the live alarm and selection levels
module cas_sync #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_nrst,
  // alarm levels
  cas_alarm_if.sync  bus
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  // stage1 feeds stage2 only; nothing else may look at it
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= bus.raw;
      stage2 <= stage1;
    end
  end

  assign bus.synced = stage2;

endmodule // cas_sync

// File: test/clock_alarm_status_regs_tb.sv
module clock_alarm_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic       clk_sys  = 1'b0;
  logic       nrst     = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr   = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_rd   = 1'b0;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       ref_los  = 1'b0;
  logic       a_los    = 1'b0;
  logic       b_los    = 1'b0;
  logic       unlock   = 1'b0;
  logic       a_off    = 1'b0;
  logic       b_off    = 1'b0;
  logic       skew_busy = 1'b0;
  logic       hold_rdy = 1'b0;
  logic       a_sel    = 1'b0;
  logic       b_sel    = 1'b0;
  logic [7:0] prediv;
  logic [2:0] rng_a;
  logic [2:0] rng_b;
  logic       irq;
  int         err_total  = 0;
  int         n_compared = 0;

  always #20 clk_sys = ~clk_sys;

  cas_regs dut_u (
    .i_clk_sys                  (clk_sys),
    .i_nrst                     (nrst),
    .i_reg_addr                 (reg_addr),
    .i_reg_wr                   (reg_wr),
    .i_reg_wdata                (reg_wdata),
    .i_reg_rd                   (reg_rd),
    .o_reg_rdata                (reg_rdata),
    .o_reg_rvalid               (reg_rvalid),
    .i_reference_signal_loss    (ref_los),
    .i_input_a_signal_loss      (a_los),
    .i_input_b_signal_loss      (b_los),
    .i_pll_unlock               (unlock),
    .i_input_a_offset           (a_off),
    .i_input_b_offset           (b_off),
    .i_coarse_skew_busy         (skew_busy),
    .i_holdover_ready           (hold_rdy),
    .i_input_a_selected         (a_sel),
    .i_input_b_selected         (b_sel),
    .o_alt_input_predivider_low (prediv),
    .o_input_a_range_select     (rng_a),
    .o_input_b_range_select     (rng_b),
    .o_irq                      (irq)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes rise and fall on falling edges, one cycle apart per call
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
  endtask

  task automatic reg_check(input string what, input logic [7:0] addr,
                           input logic [7:0] exp);
    int i;
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++) @(negedge clk_sys);
    if (reg_rvalid !== 1'b1) chk({what, " rvalid"}, 8'h00, 8'h01);
    else chk(what, reg_rdata, exp);
  endtask

  // live inputs pass a two-flop synchroniser, flags one edge later
  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_settings();
    logic [2:0] ca;
    logic [2:0] cb;
    chk("irq after reset", {7'h00, irq}, 8'h00);
    reg_check("predivider reset", cas_pkg::ADDR_PREDIV_LO, 8'h00);
    reg_check("range reset", cas_pkg::ADDR_RANGE, 8'h00);
    for (int k = 0; k < 8; k++) begin
      reg_write(cas_pkg::ADDR_PREDIV_LO, 8'h01 << k);
      chk("predivider out", prediv, 8'h01 << k);
    end
    reg_write(cas_pkg::ADDR_PREDIV_LO, 8'hff);
    reg_check("predivider all ones", cas_pkg::ADDR_PREDIV_LO, 8'hff);
    // every documented code once per field, never 110 or 111
    for (int c = 0; c < 6; c++) begin
      ca = 3'(c);
      cb = 3'(5 - c);
      reg_write(cas_pkg::ADDR_RANGE, {2'b11, cb, ca});
      chk("range a out", {5'h00, rng_a}, {5'h00, ca});
      chk("range b out", {5'h00, rng_b}, {5'h00, cb});
      reg_check("range readback", cas_pkg::ADDR_RANGE,
                {2'b00, cb, ca});
    end
    $display("test settings done");
  endtask

  task automatic t_active_and_loss();
    logic [4:0] v;
    for (int i = 0; i < 32; i++) begin
      v = 5'(i);
      {ref_los, b_sel, a_sel, b_los, a_los} = v;
      settle();
      reg_check("active", cas_pkg::ADDR_ACTIVE,
                {6'h00, v[3] & ~v[1], v[2] & ~v[0]});
      reg_check("loss live", cas_pkg::ADDR_LOS,
                {5'h00, v[1], v[0], v[4]});
    end
    {ref_los, b_sel, a_sel, b_los, a_los} = 5'h00;
    settle();
    $display("test active and loss done");
  endtask

  task automatic t_status();
    logic [4:0] v;
    logic [7:0] e;
    // held frequency is not trusted until the ready bit reads 1
    reg_check("holdover not ready", cas_pkg::ADDR_STAT, 8'h00);
    for (int j = 0; j < 6; j++) begin
      v = (j == 5) ? 5'h1f : 5'h01 << j;
      {skew_busy, hold_rdy, b_off, a_off, unlock} = v;
      settle();
      e = {v[4], v[3], 3'b000, v[2], v[1], v[0]};
      reg_check("status", cas_pkg::ADDR_STAT, e);
    end
    {skew_busy, hold_rdy, b_off, a_off, unlock} = 5'h00;
    settle();
    $display("test status done");
  endtask

  task automatic t_read_only();
    reg_write(cas_pkg::ADDR_ACTIVE, 8'hff);
    reg_write(cas_pkg::ADDR_LOS, 8'hff);
    reg_write(cas_pkg::ADDR_STAT, 8'hff);
    reg_check("active after write", cas_pkg::ADDR_ACTIVE, 8'h00);
    reg_check("loss after write", cas_pkg::ADDR_LOS, 8'h00);
    reg_check("status after write", cas_pkg::ADDR_STAT, 8'h00);
    reg_check("unmapped read", 8'h55, 8'h00);
    $display("test read only done");
  endtask

  task automatic t_sticky();
    reg_write(cas_pkg::ADDR_LOS_FLAG, 8'h00);
    reg_write(cas_pkg::ADDR_STAT_FLAG, 8'h00);
    reg_write(cas_pkg::ADDR_INT_CTRL, 8'h01);
    reg_write(cas_pkg::ADDR_LOS_MASK, 8'h00);
    reg_write(cas_pkg::ADDR_STAT_MASK, 8'h00);
    settle();
    chk("irq idle", {7'h00, irq}, 8'h00);
    a_los = 1'b1;
    settle();
    a_los = 1'b0;
    settle();
    reg_check("loss flag held", cas_pkg::ADDR_LOS_FLAG, 8'h02);
    chk("irq on flag", {7'h00, irq}, 8'h01);
    reg_write(cas_pkg::ADDR_LOS_FLAG, 8'h00);
    settle();
    reg_check("loss flag cleared", cas_pkg::ADDR_LOS_FLAG, 8'h00);
    chk("irq after clear", {7'h00, irq}, 8'h00);
    // a clear while the alarm is still live must not drop the flag
    a_los = 1'b1;
    settle();
    reg_write(cas_pkg::ADDR_LOS_FLAG, 8'h00);
    reg_check("loss flag set wins", cas_pkg::ADDR_LOS_FLAG, 8'h02);
    a_los = 1'b0;
    settle();
    reg_write(cas_pkg::ADDR_LOS_FLAG, 8'h00);
    reg_write(cas_pkg::ADDR_LOS_MASK, 8'h02);
    a_los = 1'b1;
    settle();
    a_los = 1'b0;
    settle();
    reg_check("masked flag", cas_pkg::ADDR_LOS_FLAG, 8'h02);
    chk("irq masked", {7'h00, irq}, 8'h00);
    reg_write(cas_pkg::ADDR_LOS_FLAG, 8'h00);
    unlock = 1'b1;
    settle();
    unlock = 1'b0;
    settle();
    reg_write(cas_pkg::ADDR_STAT_FLAG, 8'hff);
    reg_check("unlock flag kept", cas_pkg::ADDR_STAT_FLAG, 8'h02);
    chk("irq on unlock", {7'h00, irq}, 8'h01);
    reg_write(cas_pkg::ADDR_INT_CTRL, 8'h00);
    settle();
    chk("irq pin disabled", {7'h00, irq}, 8'h00);
    reg_write(cas_pkg::ADDR_STAT_FLAG, 8'h00);
    reg_check("unlock flag cleared", cas_pkg::ADDR_STAT_FLAG, 8'h00);
    $display("test sticky done");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    t_settings();
    t_active_and_loss();
    t_status();
    t_read_only();
    t_sticky();
    end_sim();
  end

  // the whole run needs about 450 cycles; allow about eleven times that
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule // clock_alarm_status_regs_tb
